// ### pdm_pkg.sv
// constants and types for the port pin drive mode block
// Contract
// - The port-0 low mode register sits at address AC, pin n of 0..3 uses bits 2n+1:2n, and it resets to zero.
// - The port-0 high mode register sits at address AD, pins 7..4 use bit pairs 7-6 down to 1-0, reset zero.
// - The port-1 low mode register sits at address AE, pins 3..0 use bit pairs 7-6 down to 1-0, reset zero.
// - Each port-0 field decodes 00 quasi with pull-up, 01 push-pull, 10 open-drain and 11 input only.
// - Port-0 pins follow the external bus when external access or the memory select is active, over the fields.
package pdm_pkg;

    ////////////////////////////////////////////////////////////////////////////////
    // register addresses on the special function bus
    localparam logic [7:0] PDM_ADDR_P0_LOW  = 8'hAC;
    localparam logic [7:0] PDM_ADDR_P0_HIGH = 8'hAD;
    localparam logic [7:0] PDM_ADDR_P1_LOW  = 8'hAE;

    // values after reset
    localparam logic [7:0] PDM_RESET_MODE   = 8'h00;
    localparam logic [7:0] PDM_RESET_RDATA  = 8'h00;
    localparam logic [7:0] PDM_RESET_PINS   = 8'h00;

    // field layout: pin n of a register uses bits FIELD_W*n+1 : FIELD_W*n
    localparam int         PDM_FIELD_W      = 2;
    localparam int         PDM_P0_PINS      = 8;
    localparam int         PDM_P1_PINS      = 4;

    // drive mode codes
    localparam logic [1:0] PDM_MODE_QUASI   = 2'h0;
    localparam logic [1:0] PDM_MODE_PUSH    = 2'h1;
    localparam logic [1:0] PDM_MODE_DRAIN   = 2'h2;
    localparam logic [1:0] PDM_MODE_INPUT   = 2'h3;

    ////////////////////////////////////////////////////////////////////////////////
    // pad driver controls for one pin
    typedef struct packed {
        logic out;
        logic oe;
        logic pull_up;
    } pdm_drive_type;

    // external bus override for port 0
    typedef struct packed {
        logic       active;
        logic [7:0] data;
        logic       oe;
    } pdm_ext_type;

endpackage

// ### pdm_pin_decode.sv
// drive mode decoder for one port pin
`timescale 1ns/100ps
module pdm_pin_decode (
    input  wire logic                   mode,
    input  wire logic [1:0]             mode_code,
    input  wire logic                   data,
    input  wire logic                   ext_active,
    input  wire logic                   ext_data,
    input  wire logic                   ext_oe,
    output pdm_pkg::pdm_drive_type      drive
);

    ////////////////////////////////////////////////////////////////////////////////
    // per-mode drive levels
    wire is_quasi = (mode_code == pdm_pkg::PDM_MODE_QUASI);
    wire is_push  = (mode_code == pdm_pkg::PDM_MODE_PUSH);
    wire is_drain = (mode_code == pdm_pkg::PDM_MODE_DRAIN);

    // quasi: pull low hard, release high onto pull-up
    wire mode_oe  = (is_quasi & ~data) | is_push | (is_drain & ~data);
    wire mode_out = is_push & data;
    wire mode_pu  = is_quasi & data;

    // external bus wins over the field while active
    assign drive.out     = ext_active ? ext_data : mode_out;
    assign drive.oe      = ext_active ? ext_oe   : mode_oe;
    assign drive.pull_up = ext_active ? 1'b0     : (mode & mode_pu);

endmodule

// ### pdm_port_mode.sv
// port pin drive mode registers and pad control
`timescale 1ns/100ps
module pdm_port_mode (
    input  wire logic       mclk,
    input  wire logic       rst_n,
    input  wire logic       clk_en,
    input  wire logic [7:0] sfr_addr,
    input  wire logic       sfr_wr,
    input  wire logic       sfr_rd,
    input  wire logic [7:0] sfr_wdata,
    output logic      [7:0] sfr_rdata,
    output logic            sfr_hit,
    input  wire logic [7:0] port0_latch,
    input  wire logic [3:0] port1_latch,
    input  wire logic       external_access_n,
    input  wire logic       ext_mem_select,
    input  wire logic [7:0] ext_bus_data,
    input  wire logic       ext_bus_oe,
    input  wire logic [7:0] port0_pad_in,
    input  wire logic [3:0] port1_pad_in,
    output logic      [7:0] port0_pad_out,
    output logic      [7:0] port0_pad_oe,
    output logic      [7:0] port0_pullup,
    output logic      [3:0] port1_pad_out,
    output logic      [3:0] port1_pad_oe,
    output logic      [3:0] port1_pullup,
    output logic      [7:0] port0_pin_value,
    output logic      [3:0] port1_pin_value
);

    ////////////////////////////////////////////////////////////////////////////////
    // field of pin n from a packed register set
    function automatic logic [1:0] field_of(input logic [15:0] regs, input int pin);
        field_of = regs[pdm_pkg::PDM_FIELD_W*pin +: 2];
    endfunction

    // storage
    logic [7:0] p0_low_reg;
    logic [7:0] p0_high_reg;
    logic [7:0] p1_low_reg;
    logic [7:0] p0_low_next;
    logic [7:0] p0_high_next;
    logic [7:0] p1_low_next;
    logic [7:0] rdata_next;

    ////////////////////////////////////////////////////////////////////////////////
    // address decode and write strobes
    wire sel_p0_low  = (sfr_addr == pdm_pkg::PDM_ADDR_P0_LOW);
    wire sel_p0_high = (sfr_addr == pdm_pkg::PDM_ADDR_P0_HIGH);
    wire sel_p1_low  = (sfr_addr == pdm_pkg::PDM_ADDR_P1_LOW);
    wire sel_any     = sel_p0_low | sel_p0_high | sel_p1_low;
    wire wr_p0_low   = sfr_wr & sel_p0_low;
    wire wr_p0_high  = sfr_wr & sel_p0_high;
    wire wr_p1_low   = sfr_wr & sel_p1_low;

    // next register values, each register only from its own strobe
    assign p0_low_next  = wr_p0_low  ? sfr_wdata : p0_low_reg;
    assign p0_high_next = wr_p0_high ? sfr_wdata : p0_high_reg;
    assign p1_low_next  = wr_p1_low  ? sfr_wdata : p1_low_reg;

    // read mux, unmapped addresses read zero
    assign rdata_next = sel_p0_low  ? p0_low_reg  :
                        sel_p0_high ? p0_high_reg :
                        sel_p1_low  ? p1_low_reg  : pdm_pkg::PDM_RESET_RDATA;

    ////////////////////////////////////////////////////////////////////////////////
    // mode registers
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            p0_low_reg  <= pdm_pkg::PDM_RESET_MODE;
            p0_high_reg <= pdm_pkg::PDM_RESET_MODE;
            p1_low_reg  <= pdm_pkg::PDM_RESET_MODE;
        end else if (clk_en) begin
            p0_low_reg  <= p0_low_next;
            p0_high_reg <= p0_high_next;
            p1_low_reg  <= p1_low_next;
        end
    end

    // read data, valid the edge after the read strobe
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            sfr_rdata <= pdm_pkg::PDM_RESET_RDATA;
            sfr_hit   <= 1'b0;
        end else if (clk_en) begin
            sfr_rdata <= sfr_rd ? rdata_next : sfr_rdata;
            sfr_hit   <= sfr_rd & sel_any;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // external memory override, low-active access pin or select bit
    pdm_pkg::pdm_ext_type ext;
    assign ext.active = ~external_access_n | ext_mem_select;
    assign ext.data   = ext_bus_data;
    assign ext.oe     = ext_bus_oe;

    // per-pin decode from the next register values
    wire [15:0]             p0_fields = {p0_high_next, p0_low_next};
    wire [15:0]             p1_fields = {8'h00, p1_low_next};
    pdm_pkg::pdm_drive_type p0_drive [pdm_pkg::PDM_P0_PINS];
    pdm_pkg::pdm_drive_type p1_drive [pdm_pkg::PDM_P1_PINS];
    logic [7:0]             p0_out_nx;
    logic [7:0]             p0_oe_nx;
    logic [7:0]             p0_pu_nx;
    logic [3:0]             p1_out_nx;
    logic [3:0]             p1_oe_nx;
    logic [3:0]             p1_pu_nx;

    // port 0 pins, external bus may take over
    for (genvar n = 0; n < pdm_pkg::PDM_P0_PINS; n++) begin : g_p0
        pdm_pin_decode u_dec (
            .mode       (1'b1),
            .mode_code  (field_of(p0_fields, n)),
            .data       (port0_latch[n]),
            .ext_active (ext.active),
            .ext_data   (ext.data[n]),
            .ext_oe     (ext.oe),
            .drive      (p0_drive[n])
        );
        assign p0_out_nx[n] = p0_drive[n].out;
        assign p0_oe_nx[n]  = p0_drive[n].oe;
        assign p0_pu_nx[n]  = p0_drive[n].pull_up;
    end

    // port 1 low pins, no external override
    for (genvar n = 0; n < pdm_pkg::PDM_P1_PINS; n++) begin : g_p1
        pdm_pin_decode u_dec (
            .mode       (1'b1),
            .mode_code  (field_of(p1_fields, n)),
            .data       (port1_latch[n]),
            .ext_active (1'b0),
            .ext_data   (1'b0),
            .ext_oe     (1'b0),
            .drive      (p1_drive[n])
        );
        assign p1_out_nx[n] = p1_drive[n].out;
        assign p1_oe_nx[n]  = p1_drive[n].oe;
        assign p1_pu_nx[n]  = p1_drive[n].pull_up;
    end

    ////////////////////////////////////////////////////////////////////////////////
    // registered pad controls, new mode visible from the write edge on
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            port0_pad_out <= pdm_pkg::PDM_RESET_PINS;
            port0_pad_oe  <= pdm_pkg::PDM_RESET_PINS;
            port0_pullup  <= pdm_pkg::PDM_RESET_PINS;
            port1_pad_out <= pdm_pkg::PDM_RESET_PINS[3:0];
            port1_pad_oe  <= pdm_pkg::PDM_RESET_PINS[3:0];
            port1_pullup  <= pdm_pkg::PDM_RESET_PINS[3:0];
        end else if (clk_en) begin
            port0_pad_out <= p0_out_nx;
            port0_pad_oe  <= p0_oe_nx;
            port0_pullup  <= p0_pu_nx;
            port1_pad_out <= p1_out_nx;
            port1_pad_oe  <= p1_oe_nx;
            port1_pullup  <= p1_pu_nx;
        end
    end

    // pin levels sampled back for the core
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            port0_pin_value <= pdm_pkg::PDM_RESET_PINS;
            port1_pin_value <= pdm_pkg::PDM_RESET_PINS[3:0];
        end else if (clk_en) begin
            port0_pin_value <= port0_pad_in;
            port1_pin_value <= port1_pad_in;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // checks on stored values
    a_low_write_store: assert property (@(posedge mclk) disable iff (!rst_n)
        clk_en && wr_p0_low |=> p0_low_reg == $past(sfr_wdata))
        else $error("port0 low mode write not stored");

    a_high_write_store: assert property (@(posedge mclk) disable iff (!rst_n)
        clk_en && wr_p0_high |=> p0_high_reg == $past(sfr_wdata))
        else $error("port0 high mode write not stored");

    a_p1_write_store: assert property (@(posedge mclk) disable iff (!rst_n)
        clk_en && wr_p1_low |=> p1_low_reg == $past(sfr_wdata))
        else $error("port1 low mode write not stored");

    a_field_isolation: assert property (@(posedge mclk) disable iff (!rst_n)
        clk_en && wr_p0_low |=> $stable(p0_high_reg) && $stable(p1_low_reg))
        else $error("write to one mode register changed another");

    a_read_back_value: assert property (@(posedge mclk) disable iff (!rst_n)
        clk_en && sfr_rd && sel_p1_low
        |=> sfr_rdata == $past(p1_low_reg) && sfr_hit)
        else $error("mode register read returned wrong value");

    // checks on pad drive
    a_push_pull_drive: assert property (@(posedge mclk) disable iff (!rst_n)
        clk_en && !ext.active && p0_low_next[1:0] == pdm_pkg::PDM_MODE_PUSH
        |=> port0_pad_oe[0] && port0_pad_out[0] == $past(port0_latch[0]) && !port0_pullup[0])
        else $error("port0 pin0 push-pull drive wrong");

    a_drain_release: assert property (@(posedge mclk) disable iff (!rst_n)
        clk_en && !ext.active && p0_high_next[7:6] == pdm_pkg::PDM_MODE_DRAIN && port0_latch[7]
        |=> !port0_pad_oe[7] && !port0_pullup[7])
        else $error("port0 pin7 open-drain did not release");

    a_input_only_p1: assert property (@(posedge mclk) disable iff (!rst_n)
        clk_en && p1_low_next[5:4] == pdm_pkg::PDM_MODE_INPUT
        |=> !port1_pad_oe[2] && !port1_pullup[2])
        else $error("port1 pin2 input-only still drives");

    a_ext_override: assert property (@(posedge mclk) disable iff (!rst_n)
        clk_en && ext.active
        |=> port0_pad_oe == {8{$past(ext_bus_oe)}} && port0_pad_out == $past(ext_bus_data)
            && port0_pullup == 8'h00)
        else $error("external bus did not take over port0");

    // main scenarios
    c_write_p0_low: cover property (@(posedge mclk) disable iff (!rst_n) clk_en && wr_p0_low);
    c_ext_takeover: cover property (@(posedge mclk) disable iff (!rst_n) clk_en && ext.active && |p0_low_reg);
    c_quasi_pullup: cover property (@(posedge mclk) disable iff (!rst_n) |port1_pullup);
    c_read_hit:     cover property (@(posedge mclk) disable iff (!rst_n) sfr_hit);

endmodule

// ### pdm_board.sv
// board model that resolves the levels seen on the port pads
`timescale 1ns/100ps
module pdm_board (
    input  wire logic        mclk,
    input  wire logic [11:0] pad_out,
    input  wire logic [11:0] pad_oe,
    input  wire logic [11:0] pull_en,
    input  wire logic [11:0] drv_en,
    input  wire logic [11:0] drv_val,
    output logic      [11:0] pad_in
);
    logic tog = 1'b0;

    // a floating pin shows a changing level, never a stale one
    always @(posedge mclk) tog <= ~tog;

    // pad driver wins, then board driver, then pull-up
    always_comb begin
        for (int i = 0; i < 12; i++) begin
            pad_in[i] = pad_oe[i] ? pad_out[i] : drv_en[i] ? drv_val[i] : pull_en[i] ? 1'b1 : tog;
        end
    end
endmodule

// ### tb_pdm_port_mode.sv
// testbench for the port pin drive mode block
`timescale 1ns/100ps
`define CHK(g, e) begin n_tests++; if ((g) !== (e)) begin n_errors++; \
    $display("wrong value at %0t: got %h expected %h", $time, g, e); end end
module tb_pdm_port_mode;
    logic        mclk, rst_n, clk_en, sfr_wr, sfr_rd, sfr_hit, external_access_n, ext_mem_select, ext_bus_oe;
    logic [7:0]  sfr_addr, sfr_wdata, sfr_rdata, port0_latch, ext_bus_data;
    logic [3:0]  port1_latch;
    logic [7:0]  port0_pad_in, port0_pad_out, port0_pad_oe, port0_pullup, port0_pin_value;
    logic [3:0]  port1_pad_in, port1_pad_out, port1_pad_oe, port1_pullup, port1_pin_value;
    logic [11:0] drv_en, drv_val;
    int          n_errors = 0;
    int          n_tests = 0;

    // design and board
    pdm_port_mode u_dut (.mclk(mclk), .rst_n(rst_n), .clk_en(clk_en), .sfr_addr(sfr_addr), .sfr_wr(sfr_wr),
        .sfr_rd(sfr_rd), .sfr_wdata(sfr_wdata), .sfr_rdata(sfr_rdata), .sfr_hit(sfr_hit),
        .port0_latch(port0_latch), .port1_latch(port1_latch), .external_access_n(external_access_n),
        .ext_mem_select(ext_mem_select), .ext_bus_data(ext_bus_data), .ext_bus_oe(ext_bus_oe),
        .port0_pad_in(port0_pad_in), .port1_pad_in(port1_pad_in), .port0_pad_out(port0_pad_out),
        .port0_pad_oe(port0_pad_oe), .port0_pullup(port0_pullup), .port1_pad_out(port1_pad_out),
        .port1_pad_oe(port1_pad_oe), .port1_pullup(port1_pullup), .port0_pin_value(port0_pin_value),
        .port1_pin_value(port1_pin_value));
    pdm_board u_board (.mclk(mclk), .pad_out({port1_pad_out, port0_pad_out}),
        .pad_oe({port1_pad_oe, port0_pad_oe}), .pull_en({port1_pullup, port0_pullup}),
        .drv_en(drv_en), .drv_val(drv_val), .pad_in({port1_pad_in, port0_pad_in}));

    // 25 MHz clock
    initial begin
        mclk = 1'b0;
        forever #20 mclk = ~mclk;
    end

    ////////////////////////////////////////
    // bus cycles, entered and left just after an edge
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        sfr_addr = a; sfr_wdata = d; sfr_wr = 1'b1;
        @(posedge mclk) #1 sfr_wr = 1'b0;
        @(posedge mclk) #1;
    endtask

    task automatic rd(input logic [7:0] a, input logic [7:0] d, input logic h);
        sfr_addr = a; sfr_rd = 1'b1;
        @(posedge mclk) #1 sfr_rd = 1'b0;
        `CHK(sfr_rdata, d)
        `CHK(sfr_hit, h)
        @(posedge mclk) #1;
    endtask

    // expected pad controls from mode fields and latches
    task automatic pads(input logic [15:0] m0, input logic [7:0] m1);
        logic [11:0] o, e, p;
        logic [1:0]  m;
        logic        l;
        for (int i = 0; i < 12; i++) begin
            m = i < 8 ? m0[2*i+:2] : m1[2*(i-8)+:2];
            l = i < 8 ? port0_latch[i] : port1_latch[i-8];
            e[i] = (m == 2'h0 && !l) || m == 2'h1 || (m == 2'h2 && !l);
            o[i] = m == 2'h1 && l;
            p[i] = m == 2'h0 && l;
        end
        @(posedge mclk) #1;
        `CHK({port1_pad_oe, port0_pad_oe}, e)
        `CHK({port1_pad_out, port0_pad_out} & e, o)
        `CHK({port1_pullup, port0_pullup}, p)
    endtask

    ////////////////////////////////////////
    // scenarios
    task automatic t_reset;
        rd(8'hAC, 8'h00, 1'b1);
        rd(8'hAD, 8'h00, 1'b1);
        rd(8'hAE, 8'h00, 1'b1);
        rd(8'hAF, 8'h00, 1'b0);
        port0_latch = 8'h5A; port1_latch = 4'h9;
        pads(16'h0000, 8'h00);
        $display("test reset done");
    endtask

    task automatic t_modes;
        for (int m = 0; m < 4; m++) begin
            for (int l = 0; l < 2; l++) begin
                wr(8'hAC, {4{m[1:0]}}); wr(8'hAD, {4{m[1:0]}}); wr(8'hAE, {4{m[1:0]}});
                port0_latch = {8{l[0]}}; port1_latch = {4{l[0]}};
                pads({8{m[1:0]}}, {4{m[1:0]}});
            end
        end
        $display("test modes done");
    endtask

    task automatic t_fields;
        port0_latch = 8'hA5; port1_latch = 4'h6;
        wr(8'hAC, 8'h1B); wr(8'hAD, 8'hE4); wr(8'hAE, 8'h9C); wr(8'hAF, 8'hFF);
        pads(16'hE41B, 8'h9C);
        rd(8'hAC, 8'h1B, 1'b1);
        rd(8'hAD, 8'hE4, 1'b1);
        clk_en = 1'b0;
        wr(8'hAE, 8'h00);
        clk_en = 1'b1;
        rd(8'hAE, 8'h9C, 1'b1);
        $display("test fields done");
    endtask

    task automatic t_override;
        ext_bus_data = 8'h3C; ext_bus_oe = 1'b1; external_access_n = 1'b0;
        @(posedge mclk) #1;
        `CHK(port0_pad_out, 8'h3C)
        `CHK({port0_pad_oe, port0_pullup}, 16'hFF00)
        external_access_n = 1'b1; ext_mem_select = 1'b1; ext_bus_oe = 1'b0;
        @(posedge mclk) #1;
        `CHK({port0_pad_oe, port0_pullup}, 16'h0000)
        ext_mem_select = 1'b0;
        pads(16'hE41B, 8'h9C);
        $display("test override done");
    endtask

    task automatic t_pins;
        wr(8'hAC, 8'hFF); wr(8'hAD, 8'hFF); wr(8'hAE, 8'hFF);
        drv_en = 12'hFFF; drv_val = 12'h96B;
        repeat (2) @(posedge mclk);
        #1;
        `CHK({port1_pin_value, port0_pin_value}, 12'h96B)
        drv_en = 12'h000; port0_latch = 8'hFF;
        wr(8'hAC, 8'h00);
        @(posedge mclk) #1;
        `CHK(port0_pin_value[3:0], 4'hF)
        $display("test pins done");
    endtask

    // verdict and end of run
    task final_report;
        $display("comparisons %0d mismatches %0d", n_tests, n_errors);
        if (n_errors == 0 && n_tests > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    // watchdog well beyond the expected run
    initial begin
        #200000;
        n_errors++;
        final_report;
    end

    // reset, then the scenarios in turn
    initial begin
        rst_n = 1'b0; clk_en = 1'b1; sfr_addr = 8'h00; sfr_wr = 1'b0; sfr_rd = 1'b0; sfr_wdata = 8'h00;
        port0_latch = 8'h00; port1_latch = 4'h0; external_access_n = 1'b1; ext_mem_select = 1'b0;
        ext_bus_data = 8'h00; ext_bus_oe = 1'b0; drv_en = 12'h000; drv_val = 12'h000;
        repeat (12) @(posedge mclk);
        #1 rst_n = 1'b1;
        t_reset;
        t_modes;
        t_fields;
        t_override;
        t_pins;
        final_report;
    end
endmodule
